// *** src/lps_cfg.svh ***
// timing counts and command bytes for the display power sequencer
`ifndef LPS_CFG_SVH
`define LPS_CFG_SVH
`define LPS_CLK_HZ          25000000
`define LPS_REL_WAIT_NS     10000
`define LPS_REL_WAIT_CYC    ((`LPS_REL_WAIT_NS * 25 + 999) / 1000)
`define LPS_OFF_WAIT_MS     50
`define LPS_OFF_WAIT_CYC    (`LPS_OFF_WAIT_MS * (`LPS_CLK_HZ / 1000))
`define LPS_CMD_BIAS        8'hA2
`define LPS_CMD_SEG_NORM    8'hA0
`define LPS_CMD_COM_REV     8'hC8
`define LPS_CMD_BOOST       8'hF8
`define LPS_BOOST_4X        8'h00
`define LPS_BOOST_5X        8'h01
`define LPS_CMD_REG_RATIO   8'h25
`define LPS_CMD_CONTRAST    8'h81
`define LPS_CONTRAST_DFLT   8'h1B
`define LPS_CMD_PWR_BOOST   8'h2C
`define LPS_CMD_PWR_REG     8'h2E
`define LPS_CMD_PWR_FOLLOW  8'h2F
`define LPS_CMD_DISP_ON     8'hAF
`define LPS_CMD_DISP_OFF    8'hAE
`define LPS_CMD_ALL_ON      8'hA5
`define LPS_INIT_LEN        4'hD
`endif

// *** src/lps_pkg.sv ***
// types for the display power sequencer
package lps_pkg;
    typedef enum logic [2:0] {
        LPS_OFF,
        LPS_WAIT_REL,
        LPS_INIT,
        LPS_RUN,
        LPS_SAVE,
        LPS_HOLD,
        LPS_DONE
    } lps_state_t;
endpackage : lps_pkg

// *** src/lps_delay.sv ***
// down-counter that signals when a wait has elapsed
module lps_delay #(
    parameter int WIDTH = 24
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] count,
    output logic                  expired
);
    logic [WIDTH-1:0] remain;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            remain <= '0;
        end else if (load) begin
            remain <= count;
        end else if (remain != '0) begin
            remain <= remain - 1'b1;
        end
    end

    // a fresh load never reads as expired in the same cycle
    assign expired = (remain == '0) && !load;
endmodule : lps_delay

// *** src/lps_rom.sv ***
// init command byte table, booster and contrast choices patched in
module lps_rom (
    input  wire logic [3:0] index,
    input  wire logic       boost_5x,
    input  wire logic [7:0] contrast,
    output logic [7:0]      cmd
);
    `include "lps_cfg.svh"

    always_comb begin
        unique case (index)
            4'h0:    cmd = `LPS_CMD_BIAS;
            4'h1:    cmd = `LPS_CMD_SEG_NORM;
            4'h2:    cmd = `LPS_CMD_COM_REV;
            4'h3:    cmd = `LPS_CMD_BOOST;
            4'h4:    cmd = boost_5x ? `LPS_BOOST_5X : `LPS_BOOST_4X;
            4'h5:    cmd = `LPS_CMD_REG_RATIO;
            4'h6:    cmd = `LPS_CMD_CONTRAST;
            4'h7:    cmd = contrast;
            4'h8:    cmd = `LPS_CMD_PWR_BOOST;
            4'h9:    cmd = `LPS_CMD_PWR_REG;
            4'hA:    cmd = `LPS_CMD_PWR_FOLLOW;
            4'hB:    cmd = `LPS_CMD_DISP_ON;
            4'hC:    cmd = `LPS_CMD_DISP_OFF;
            4'hD:    cmd = `LPS_CMD_ALL_ON;
            default: cmd = 8'h00;
        endcase
    end
endmodule : lps_rom

// *** src/lps_seq.sv ***
// host-side power-up / power-down sequencer for the graphic display module
`include "lps_cfg.svh"

module lps_seq #(
    parameter int OFF_WAIT_CYC = `LPS_OFF_WAIT_CYC,
    parameter int REL_WAIT_CYC = `LPS_REL_WAIT_CYC
) (
    input  wire logic       CLK_SYS,
    input  wire logic       ARST_N,
    input  wire logic       SUPPLY_OK,
    input  wire logic       POWER_DOWN_REQ,
    input  wire logic       BOOST_5X,
    input  wire logic [7:0] CONTRAST,
    input  wire logic       CMD_DONE,
    output logic            MODULE_CLEAR_LINE_N,
    output logic            CMD_VALID,
    output logic [7:0]      CMD_BYTE,
    output logic            READY,
    output logic            POWER_OFF_OK
);
    localparam int CW = 24;

    lps_pkg::lps_state_t state;
    logic [3:0]          index;
    logic [7:0]          rom_cmd;
    logic                wait_load;
    logic                wait_expired;
    logic [CW-1:0]       wait_count;

    lps_rom u_rom (
        .index    (index),
        .boost_5x (BOOST_5X),
        .contrast (CONTRAST),
        .cmd      (rom_cmd)
    );

    lps_delay #(.WIDTH(CW)) u_delay (
        .clk     (CLK_SYS),
        .arst_n  (ARST_N),
        .load    (wait_load),
        .count   (wait_count),
        .expired (wait_expired)
    );

    // one load pulse on entry to each timed state
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            wait_load  <= 1'b0;
            wait_count <= '0;
        end else begin
            wait_load <= 1'b0;
            if (state == lps_pkg::LPS_OFF && SUPPLY_OK) begin
                wait_load  <= 1'b1;
                wait_count <= CW'(REL_WAIT_CYC);
            end else if (state == lps_pkg::LPS_SAVE && CMD_DONE && index == `LPS_INIT_LEN) begin
                wait_load  <= 1'b1;
                wait_count <= CW'(OFF_WAIT_CYC);
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            state <= lps_pkg::LPS_OFF;
            index <= 4'h0;
        end else begin
            unique case (state)
                lps_pkg::LPS_OFF: begin
                    if (SUPPLY_OK) begin
                        state <= lps_pkg::LPS_WAIT_REL;
                    end
                end
                lps_pkg::LPS_WAIT_REL: begin
                    // load lands one cycle late, so skip the first look
                    if (wait_expired && !wait_load && CMD_VALID == 1'b0 && index == 4'h0
                        && MODULE_CLEAR_LINE_N) begin
                        state <= lps_pkg::LPS_INIT;
                    end
                end
                lps_pkg::LPS_INIT: begin
                    if (CMD_DONE) begin
                        if (index == 4'hB) begin
                            state <= lps_pkg::LPS_RUN;
                        end
                        index <= index + 4'h1;
                    end
                end
                lps_pkg::LPS_RUN: begin
                    if (POWER_DOWN_REQ) begin
                        state <= lps_pkg::LPS_SAVE;
                    end
                end
                lps_pkg::LPS_SAVE: begin
                    if (CMD_DONE) begin
                        if (index == `LPS_INIT_LEN) begin
                            state <= lps_pkg::LPS_HOLD;
                        end else begin
                            index <= index + 4'h1;
                        end
                    end
                end
                lps_pkg::LPS_HOLD: begin
                    if (wait_expired && !wait_load) begin
                        state <= lps_pkg::LPS_DONE;
                    end
                end
                lps_pkg::LPS_DONE: begin
                    if (!SUPPLY_OK) begin
                        state <= lps_pkg::LPS_OFF;
                        index <= 4'h0;
                    end
                end
            endcase
        end
    end

    // clear line: high only between release and the power-down hold
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            MODULE_CLEAR_LINE_N <= 1'b0;
        end else if (state == lps_pkg::LPS_OFF) begin
            MODULE_CLEAR_LINE_N <= SUPPLY_OK;
        end else if (state == lps_pkg::LPS_HOLD || state == lps_pkg::LPS_DONE) begin
            MODULE_CLEAR_LINE_N <= 1'b0;
        end
    end

    // command strobe: held until the writer reports completion, then dropped one cycle
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            CMD_VALID <= 1'b0;
            CMD_BYTE  <= 8'h00;
        end else if (CMD_VALID) begin
            if (CMD_DONE) begin
                CMD_VALID <= 1'b0;
            end
        end else if (state == lps_pkg::LPS_INIT || state == lps_pkg::LPS_SAVE) begin
            CMD_VALID <= 1'b1;
            CMD_BYTE  <= rom_cmd;
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            READY        <= 1'b0;
            POWER_OFF_OK <= 1'b0;
        end else begin
            READY        <= (state == lps_pkg::LPS_RUN);
            POWER_OFF_OK <= (state == lps_pkg::LPS_DONE);
        end
    end
endmodule : lps_seq

// *** testbench/lps_seq_assertions.sv ***
// port checker for the display power sequencer
module lps_seq_assertions (
    input wire logic       CLK_SYS,
    input wire logic       ARST_N,
    input wire logic       SUPPLY_OK,
    input wire logic       CMD_DONE,
    input wire logic       MODULE_CLEAR_LINE_N,
    input wire logic       CMD_VALID,
    input wire logic [7:0] CMD_BYTE,
    input wire logic       READY,
    input wire logic       POWER_OFF_OK
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] INIT [14] = '{8'hA2, 8'hA0, 8'hC8, 8'hF8, 8'h00, 8'h25, 8'h81, 8'h00,
                                         8'h2C, 8'h2E, 8'h2F, 8'hAF, 8'hAE, 8'hA5};
    logic [8:0] rel;
    logic [3:0] n;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);
    // saturates so a long run never wraps under the wait
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) rel <= 9'h000;
        else if (!MODULE_CLEAR_LINE_N) rel <= 9'h000;
        else if (rel != 9'h1FF) rel <= rel + 9'h001;
    end
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) n <= 4'h0;
        else if (!SUPPLY_OK) n <= 4'h0;
        else if (CMD_VALID && CMD_DONE) n <= n + 4'h1;
    end
    AST_CLR_HOLD: assert property (!SUPPLY_OK && !MODULE_CLEAR_LINE_N |=> !MODULE_CLEAR_LINE_N)
        else $error("clear line released early");
    AST_REL_WAIT: assert property (CMD_VALID |-> rel >= 9'h0FA)
        else $error("command too soon after release");
    AST_INIT_ORDER:
        assert property (CMD_VALID && n < 4'hC && n != 4'h4 && n != 4'h7 |-> CMD_BYTE == INIT[n])
        else $error("init byte out of order");
    AST_OFF_PAIR: assert property (CMD_VALID && n > 4'hB |-> CMD_BYTE == INIT[n])
        else $error("bad shutdown byte");
    AST_STAND: assert property (CMD_VALID && !CMD_DONE |=> CMD_VALID && $stable(CMD_BYTE))
        else $error("byte withdrawn before written");
    AST_TAKEN: assert property (CMD_VALID && CMD_DONE |=> !CMD_VALID)
        else $error("byte held after written");
    AST_READY: assert property ($rose(READY) |-> n == 4'hC)
        else $error("ready before display on");
    AST_OFF_OK: assert property ($rose(POWER_OFF_OK) |-> n == 4'hE && !$past(MODULE_CLEAR_LINE_N, 8))
        else $error("power off too early");
endmodule : lps_seq_assertions
bind lps_seq lps_seq_assertions chk_u (.*);

// *** testbench/lps_lcd_model.sv ***
// display module stand-in taking command bytes with a set latency
module lps_lcd_model (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       valid,
    input wire logic [7:0] cmd,
    input wire logic [3:0] lat,
    output logic           done,
    output logic           saver
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] w;
    logic       taken;
    logic       off;
    // waits for valid to fall so no byte is acknowledged twice
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {done, taken, w} <= '0;
        end else begin
            done <= 1'b0;
            if (!valid) taken <= 1'b0;
            else if (!taken && w >= lat) begin
                {done, taken, w} <= {2'b11, 4'h0};
            end else if (!taken) w <= w + 4'h1;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) {off, saver} <= 2'b00;
        else if (valid && done) begin
            off <= cmd == 8'hAE;
            if (cmd == 8'hAF) saver <= 1'b0;
            if (off && cmd == 8'hA5) saver <= 1'b1;
        end
    end
endmodule : lps_lcd_model

// *** testbench/tb.sv ***
// self-checking bench for the display power sequencer
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OFF = 20;
    logic       clk, arst_n, supply_ok, pdr, b5, done, clr_n, valid, ready, off_ok, saver;
    logic [7:0] con, cmd;
    logic [3:0] lat;
    logic [7:0] got [$];
    int         err_count, checks;
    lps_seq #(.OFF_WAIT_CYC(OFF), .REL_WAIT_CYC(250)) dut_u (.CLK_SYS(clk), .ARST_N(arst_n),
        .SUPPLY_OK(supply_ok), .POWER_DOWN_REQ(pdr), .BOOST_5X(b5), .CONTRAST(con), .CMD_DONE(done),
        .MODULE_CLEAR_LINE_N(clr_n), .CMD_VALID(valid), .CMD_BYTE(cmd), .READY(ready), .POWER_OFF_OK(off_ok));
    lps_lcd_model mdl_u (.clk(clk), .arst_n(arst_n), .valid(valid), .cmd(cmd), .lat(lat), .done(done), .saver(saver));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) if (valid && done) got.push_back(cmd);
    function automatic logic [7:0] exp_byte(input int i);
        logic [7:0] t [14] = '{8'hA2, 8'hA0, 8'hC8, 8'hF8, 8'h00, 8'h25, 8'h81, 8'h00,
                               8'h2C, 8'h2E, 8'h2F, 8'hAF, 8'hAE, 8'hA5};
        if (i == 4) return {7'h00, b5};
        if (i == 7) return con;
        return t[i];
    endfunction : exp_byte
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    // early holds the shutdown request through init, which must be ignored
    task automatic run(input int k, input logic b, input logic [7:0] c, input logic [3:0] l, input logic early);
        int n;
        int low;
        got.delete();
        {b5, con, lat, pdr} = {b, c, l, early};
        tick(5);
        chk(clr_n, 1'b0);
        supply_ok = 1'b1;
        n = 0;
        while (!ready && n < 3000) begin
            tick(1);
            n++;
        end
        chk(ready, 1'b1);
        chk(got.size(), 12);
        pdr = 1'b1;
        {n, low} = '0;
        while (!off_ok && n < 3000) begin
            tick(1);
            n++;
            low += !clr_n;
        end
        chk(off_ok, 1'b1);
        chk(ready, 1'b0);
        chk(low > OFF, 1'b1);
        chk(got.size(), 14);
        for (int i = 0; i < 14; i++) chk(got[i], exp_byte(i));
        chk(saver, 1'b1);
        {pdr, supply_ok} = 2'b00;
        tick(3);
        chk(clr_n, 1'b0);
        chk(off_ok, 1'b0);
        $display("test %0d done", k);
    endtask : run
    initial begin
        void'($urandom(32'h8488));
        {arst_n, supply_ok, pdr, b5, con, lat, err_count, checks} = '0;
        tick(8);
        arst_n = 1'b1;
        run(0, 1'b0, 8'h1B, 4'h0, 1'b0);
        run(1, 1'b1, 8'hFF, 4'hF, 1'b1);
        // reset in mid-init must drop every output; a fresh power-up follows
        supply_ok = 1'b1;
        tick(300);
        chk(clr_n, 1'b1);
        {arst_n, supply_ok} = 2'b00;
        tick(2);
        chk({clr_n, valid, ready, off_ok}, 4'h0);
        arst_n = 1'b1;
        tick(2);
        chk({clr_n, valid, ready, off_ok}, 4'h0);
        for (int k = 2; k < 5; k++) run(k, 1'($urandom), 8'($urandom), 4'($urandom), 1'($urandom));
        finish_test();
    end
    initial begin
        #(40 * 30000);
        err_count++;
        finish_test();
    end
endmodule : tb
